// ### src/adcsq_top.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "adcsq_consts.svh"

// Function
// [RULE1] pin enable routes pin as analog channel
// [RULE2] analog pin disconnects its pull-high
// [RULE3] analog pin overrides port direction
// [RULE4] external source codes pick pins 0 to 7
// [RULE5] external source, high channel code: floating
// [RULE6] bandgap source with high channel code
// [RULE7] ground source codes with high channel code
// [RULE8] software parks channel before internal source
// [RULE9] sampling lasts four converter clocks
// [RULE10] twelve converting clocks, sixteen in total
// [RULE11] start bit low-high-low starts conversion
// [RULE12] busy high during conversion, result after
// [RULE13] power enable off stops the converter
// [RULE14] twelve-bit unsigned result, full scale FFF
// [RULE15] format bit places result across registers
// [RULE16] software enables both interrupt levels
// [RULE17] software configures in advised order
// [RULE18] reference select picks full-scale reference
// [RULE19] code 01 selects supply, else pin
// [RULE20] divider codes give divide by powers two
// [RULE21] completion sets flag, raises enabled interrupt
// [RULE22] start rise resets, fall launches sampling
// [RULE23] results and busy change together
module adcsq_top #(
  parameter int PINS = 8,
  parameter int RES_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADCSQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] port_dir_input,
  input wire logic [PINS-1:0] port_pullup_req,
  output logic [PINS-1:0] pin_analog_en,
  output logic [PINS-1:0] pin_pullup_en,
  output logic [PINS-1:0] pin_oe_n,
  output logic [PINS-1:0] chan_connect,
  output logic bandgap_connect,
  output logic ground_connect,
  output logic ref_supply_sel,
  output logic converter_power_on,
  output logic sample_en,
  output adcsq_pkg::adcsq_code_t dac_code,
  input wire logic cmp_above,
  output logic conv_irq
);
  import adcsq_pkg::*;

  // ===================================================================
  // decode helpers
  function automatic logic src_is_ext(input logic [2:0] src);
    return (src == `ADCSQ_SRC_EXT) || (src > `ADCSQ_SRC_GND_HI);
  endfunction

  function automatic logic src_is_gnd(input logic [2:0] src);
    return (src >= `ADCSQ_SRC_GND_LO) && (src <= `ADCSQ_SRC_GND_HI);
  endfunction

  // ===================================================================
  // registers
  adcsq_byte_t ctrl1_q;
  adcsq_byte_t ctrl2_q;
  adcsq_byte_t pin_en_q;
  logic flag_q;
  logic ie_q;
  logic gie_q;
  logic busy_q;
  logic start_q;
  logic start_prev_q;
  adcsq_code_t result_q;
  adcsq_byte_t res_hi_q;
  adcsq_byte_t res_lo_q;
  logic [31:0] prdata_q;
  adcsq_state_t state_q;
  logic [3:0] cnt_q;
  adcsq_code_t dac_q;
  logic cmp_meta_q;
  logic cmp_sync_q;

  logic [3:0] chan_sel;
  logic [2:0] src_sel;
  logic pwr;
  logic fmt;
  logic tick;
  logic wr;
  logic setup;
  logic mapped;
  logic start_rise;
  logic start_fall;
  logic done;
  logic [3:0] bit_idx;
  adcsq_code_t decided;

  assign chan_sel = ctrl1_q[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB];
  assign src_sel = ctrl2_q[`ADCSQ_SRC_MSB:`ADCSQ_SRC_LSB];
  assign pwr = ctrl1_q[`ADCSQ_PWR_BIT];
  assign fmt = ctrl1_q[`ADCSQ_FMT_BIT];

  // ===================================================================
  // apb slave: zero wait states, read data captured in setup phase
  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign mapped = (paddr == `ADCSQ_OFF_CTRL_FIRST) || (paddr == `ADCSQ_OFF_CTRL_SECOND) ||
                  (paddr == `ADCSQ_OFF_PIN_ENABLE) || (paddr == `ADCSQ_OFF_RESULT_HIGH) ||
                  (paddr == `ADCSQ_OFF_RESULT_LOW) || (paddr == `ADCSQ_OFF_INT_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      unique case (paddr)
        `ADCSQ_OFF_CTRL_FIRST: prdata_q <= {24'h000000, ctrl1_q[7], busy_q, ctrl1_q[5:0]};
        `ADCSQ_OFF_CTRL_SECOND: prdata_q <= {24'h000000, ctrl2_q};
        `ADCSQ_OFF_PIN_ENABLE: prdata_q <= {24'h000000, pin_en_q};
        `ADCSQ_OFF_RESULT_HIGH: prdata_q <= {24'h000000, res_hi_q}; // [RULE12]
        `ADCSQ_OFF_RESULT_LOW: prdata_q <= {24'h000000, res_lo_q}; // [RULE12]
        `ADCSQ_OFF_INT_CTRL: prdata_q <= {29'h00000000, gie_q, ie_q, flag_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // busy bit is read-only; the stored copy of that bit is unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= `ADCSQ_RST_CTRL_FIRST;
      ctrl2_q <= `ADCSQ_RST_CTRL_SECOND;
      pin_en_q <= `ADCSQ_RST_PIN_ENABLE;
    end else if (wr) begin
      if (paddr == `ADCSQ_OFF_CTRL_FIRST) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (paddr == `ADCSQ_OFF_CTRL_SECOND) begin
        ctrl2_q <= pwdata[7:0];
      end
      if (paddr == `ADCSQ_OFF_PIN_ENABLE) begin
        pin_en_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
      gie_q <= 1'b0;
    end else if (wr && paddr == `ADCSQ_OFF_INT_CTRL) begin
      ie_q <= pwdata[`ADCSQ_IE_BIT];
      gie_q <= pwdata[`ADCSQ_GIE_BIT];
    end
  end

  // write one clears; a completion in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1; // [RULE21]
    end else if (wr && paddr == `ADCSQ_OFF_INT_CTRL && pwdata[`ADCSQ_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  assign conv_irq = flag_q && ie_q && gie_q; // [RULE21]

  // ===================================================================
  // pin function override, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign pin_analog_en[gi] = pin_en_q[gi]; // [RULE1]
      assign pin_pullup_en[gi] = port_pullup_req[gi] && !pin_en_q[gi]; // [RULE2]
      // analog pins never drive, whatever the port direction says
      assign pin_oe_n[gi] = port_dir_input[gi] || pin_en_q[gi]; // [RULE1] [RULE3]
      assign chan_connect[gi] = (chan_sel == 4'(gi)); // [RULE4] [RULE5]
    end
  endgenerate

  // ===================================================================
  // internal sources; a low channel code stays connected, so a wrong
  // sequence converts the pin and leaves the internal source unconnected
  assign bandgap_connect = (src_sel == `ADCSQ_SRC_BANDGAP) &&
                           (chan_sel >= `ADCSQ_CH_FIRST_NONE); // [RULE6] [RULE8]
  assign ground_connect = src_is_gnd(src_sel) &&
                          (chan_sel >= `ADCSQ_CH_FIRST_NONE); // [RULE7]
  assign ref_supply_sel =
    (ctrl2_q[`ADCSQ_REF_MSB:`ADCSQ_REF_LSB] == `ADCSQ_REF_VDD); // [RULE18] [RULE19]
  assign converter_power_on = pwr; // [RULE13]

  // ===================================================================
  // converter clock enable
  adcsq_clkdiv #(
    .SEL_W(3),
    .CNT_W(7)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwr),
    .div_sel(ctrl2_q[`ADCSQ_DIV_MSB:`ADCSQ_DIV_LSB]),
    .tick(tick)
  );

  // ===================================================================
  // comparator synchroniser; its two-cycle lag needs a converter clock
  // of at least three pclk cycles for exact successive approximation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_above;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ===================================================================
  // start edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      start_q <= ctrl1_q[`ADCSQ_START_BIT];
      start_prev_q <= start_q;
    end
  end

  assign start_rise = start_q && !start_prev_q; // [RULE11]
  assign start_fall = !start_q && start_prev_q; // [RULE11]

  // ===================================================================
  // sequencer
  assign bit_idx = 4'(`ADCSQ_CONV_CLKS - 4'h1) - cnt_q;
  assign done = (state_q == ADCSQ_CONVERT) && tick && (cnt_q == `ADCSQ_CONV_CLKS - 4'h1);

  always_comb begin
    decided = dac_q;
    decided[bit_idx] = cmp_sync_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ADCSQ_IDLE;
      cnt_q <= '0;
    end else if (!pwr || start_rise) begin
      state_q <= pwr ? ADCSQ_ARMED : ADCSQ_IDLE; // [RULE13] [RULE22]
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ADCSQ_IDLE: begin
          cnt_q <= '0;
        end
        ADCSQ_ARMED: begin
          if (start_fall) begin
            state_q <= ADCSQ_SAMPLE; // [RULE22]
            cnt_q <= '0;
          end
        end
        ADCSQ_SAMPLE: begin
          if (tick) begin
            if (cnt_q == `ADCSQ_SAMPLE_CLKS - 4'h1) begin
              state_q <= ADCSQ_CONVERT; // [RULE9]
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ADCSQ_CONVERT: begin
          if (tick) begin
            if (done) begin
              state_q <= ADCSQ_IDLE; // [RULE10]
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  assign sample_en = (state_q == ADCSQ_SAMPLE); // [RULE9]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (!pwr || start_rise) begin
      busy_q <= 1'b0; // [RULE13]
    end else if (state_q == ADCSQ_ARMED && start_fall) begin
      busy_q <= 1'b1; // [RULE12] [RULE22]
    end else if (done) begin
      busy_q <= 1'b0; // [RULE12] [RULE23]
    end
  end

  // successive approximation: trial code starts at mid scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_q <= `ADCSQ_SAR_MSB;
    end else if (state_q != ADCSQ_CONVERT) begin
      dac_q <= `ADCSQ_SAR_MSB;
    end else if (tick && !done) begin
      dac_q <= decided | (`ADCSQ_SAR_MSB >> (cnt_q + 4'h1)); // [RULE14]
    end
  end

  assign dac_code = dac_q;

  // result and both views load on the edge that clears busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= `ADCSQ_RST_RESULT;
      res_hi_q <= '0;
      res_lo_q <= '0;
    end else if (done) begin
      result_q <= decided; // [RULE14] [RULE23]
      if (fmt) begin
        res_hi_q <= {4'h0, decided[11:8]}; // [RULE15]
        res_lo_q <= decided[7:0];
      end else begin
        res_hi_q <= decided[11:4]; // [RULE15]
        res_lo_q <= {decided[3:0], 4'h0};
      end
    end
  end

  // ===================================================================
  // checks
  logic [4:0] tick_cnt_q;
  logic [4:0] sample_ticks_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      sample_ticks_q <= '0;
    end else if (!busy_q) begin
      tick_cnt_q <= '0;
      sample_ticks_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
      if (sample_en) begin
        sample_ticks_q <= sample_ticks_q + 5'h01;
      end
    end
  end

  a_pin_override: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    pin_en_q[0] |-> pin_oe_n[0] && !pin_pullup_en[0] && pin_analog_en[0])
    else $error("analog pin still has digital functions");

  a_ext_channel: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    src_is_ext(src_sel) && chan_sel < `ADCSQ_CH_FIRST_NONE |->
      chan_connect == (PINS'(1) << chan_sel) && !bandgap_connect && !ground_connect)
    else $error("external channel routing wrong");

  a_float_input: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    src_is_ext(src_sel) && chan_sel >= `ADCSQ_CH_FIRST_NONE |->
      chan_connect == '0 && !bandgap_connect && !ground_connect)
    else $error("floating selection connects a source");

  a_internal_src: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    chan_sel >= `ADCSQ_CH_FIRST_NONE |->
      bandgap_connect == (src_sel == `ADCSQ_SRC_BANDGAP) && ground_connect == src_is_gnd(src_sel))
    else $error("internal source routing wrong");

  a_sample_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    $fell(sample_en) && busy_q |-> sample_ticks_q == 5'(`ADCSQ_SAMPLE_CLKS))
    else $error("sampling phase not four converter clocks");

  a_total_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    busy_q && done |-> tick_cnt_q == `ADCSQ_TOTAL_CLKS - 5'h01)
    else $error("conversion not sixteen converter clocks");

  a_busy_launch: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    state_q == ADCSQ_ARMED && start_fall && pwr |=> busy_q && sample_en && tick_cnt_q == 5'h00)
    else $error("start fall did not launch sampling");

  a_done_atomic: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    busy_q && done && pwr |=> !busy_q && flag_q && result_q == $past(decided))
    else $error("result, busy and flag not updated together");

  a_power_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    !pwr |-> !converter_power_on ##1 (!busy_q && !sample_en))
    else $error("converter active with power enable low");

  a_format_hi: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    done && fmt |=> res_hi_q[7:4] == 4'h0 && res_lo_q == result_q[7:0])
    else $error("right-justified format wrong");
endmodule

// ### src/adcsq_consts.svh
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// =====================================================================
// register byte offsets
`define ADCSQ_ADDR_W 8
`define ADCSQ_OFF_CTRL_FIRST 8'h00
`define ADCSQ_OFF_CTRL_SECOND 8'h04
`define ADCSQ_OFF_PIN_ENABLE 8'h08
`define ADCSQ_OFF_RESULT_HIGH 8'h0C
`define ADCSQ_OFF_RESULT_LOW 8'h10
`define ADCSQ_OFF_INT_CTRL 8'h14

// =====================================================================
// converter_control_first fields
`define ADCSQ_CH_LSB 0
`define ADCSQ_CH_MSB 3
`define ADCSQ_FMT_BIT 4
`define ADCSQ_PWR_BIT 5
`define ADCSQ_BUSY_BIT 6
`define ADCSQ_START_BIT 7

// =====================================================================
// converter_control_second fields
`define ADCSQ_DIV_LSB 0
`define ADCSQ_DIV_MSB 2
`define ADCSQ_REF_LSB 3
`define ADCSQ_REF_MSB 4
`define ADCSQ_SRC_LSB 5
`define ADCSQ_SRC_MSB 7

// =====================================================================
// interrupt control fields
`define ADCSQ_FLAG_BIT 0
`define ADCSQ_IE_BIT 1
`define ADCSQ_GIE_BIT 2

// =====================================================================
// codes, reset values and timing
`define ADCSQ_CH_FIRST_NONE 4'h8
`define ADCSQ_SRC_EXT 3'h0
`define ADCSQ_SRC_BANDGAP 3'h1
`define ADCSQ_SRC_GND_LO 3'h2
`define ADCSQ_SRC_GND_HI 3'h4
`define ADCSQ_REF_VDD 2'h1
`define ADCSQ_RST_CTRL_FIRST 8'h00
`define ADCSQ_RST_CTRL_SECOND 8'h00
`define ADCSQ_RST_PIN_ENABLE 8'h00
`define ADCSQ_RST_RESULT 12'h000
`define ADCSQ_SAMPLE_CLKS 4'h4
`define ADCSQ_CONV_CLKS 4'hC
`define ADCSQ_TOTAL_CLKS 5'h10
`define ADCSQ_SAR_MSB 12'h800

`endif

// ### src/adcsq_pkg.sv
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_ARMED,
    ADCSQ_SAMPLE,
    ADCSQ_CONVERT
  } adcsq_state_t;
  typedef logic [7:0] adcsq_byte_t;
  typedef logic [11:0] adcsq_code_t;
endpackage

// ### src/adcsq_clkdiv.sv
`timescale 1ns/1ns
`include "adcsq_consts.svh"

// =====================================================================
// converter clock enable: pclk divided by 2**div_sel
module adcsq_clkdiv #(
  parameter int SEL_W = 3,
  parameter int CNT_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [SEL_W-1:0] div_sel,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  // code 0 gives an all-zero mask, so every cycle ticks (divide by 1)
  assign mask = CNT_W'((1 << div_sel) - 1); // [RULE20]
  assign tick = run && ((cnt_q & mask) == mask); // [RULE20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule

// ### tb/adcsq_analog_model.sv
`timescale 1ns/1ns

// =====================================================================
// analog pins, bandgap and comparator seen by the sequencer
module adcsq_analog_model #(
  parameter int VDD_LVL = 4096,
  parameter int VREF_LVL = 2048,
  parameter int BANDGAP_LVL = 1200
) (
  input wire logic pclk,
  input wire logic [95:0] chan_level,
  input wire logic [7:0] chan_connect,
  input wire logic bandgap_connect,
  input wire logic ground_connect,
  input wire logic ref_supply_sel,
  input wire logic converter_power_on,
  input wire logic sample_en,
  input wire logic [11:0] dac_code,
  output logic cmp_above
);
  int lvl;
  int n;
  int code;
  int held_q = 0;
  logic float_q = 1'b1;
  logic noise_q = 1'b0;
  always_comb begin
    lvl = 0;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      if (chan_connect[i]) begin
        lvl = int'(chan_level[i*12 +: 12]);
        n++;
      end
    end
    if (bandgap_connect) begin
      lvl = BANDGAP_LVL;
      n++;
    end
    if (ground_connect) begin
      lvl = 0;
      n++;
    end
    code = lvl * 4096 / (ref_supply_sel ? VDD_LVL : VREF_LVL);
    if (code > 4095) begin
      code = 4095;
    end
  end
  // held level only follows the selected pin, bandgap or ground while sampling
  always_ff @(posedge pclk) begin
    noise_q <= ~noise_q;
    if (sample_en) begin
      held_q <= code;
      float_q <= (n != 1);
    end
  end
  // unpowered or floating input answers with a changing pattern
  assign cmp_above = (!converter_power_on || float_q) ? noise_q :
                     (held_q >= int'(dac_code));
endmodule

// ### tb/test_adc_input_select_and_sequencer.sv
`timescale 1ns/1ns
`include "adcsq_consts.svh"

module test_adc_input_select_and_sequencer;
  import adcsq_pkg::*;
  typedef struct {
    string what;
    logic [31:0] data;
    logic err;
  } adcsq_note_t;
  localparam int BG = 1200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_dir_input = 8'h00;
  logic [7:0] port_pullup_req = 8'h00;
  logic [7:0] pin_analog_en, pin_pullup_en, pin_oe_n, chan_connect;
  logic bandgap_connect, ground_connect, ref_supply_sel, converter_power_on;
  logic sample_en, cmp_above, conv_irq;
  adcsq_code_t dac_code;
  logic [95:0] chan_level = '0;
  adcsq_note_t notes[$];
  int failures = 0;
  int compares = 0;
  logic [31:0] rng = 32'd61146;
  logic [31:0] t;
  int n;

  adcsq_top #(.PINS(8), .RES_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_dir_input(port_dir_input),
    .port_pullup_req(port_pullup_req), .pin_analog_en(pin_analog_en),
    .pin_pullup_en(pin_pullup_en), .pin_oe_n(pin_oe_n), .chan_connect(chan_connect),
    .bandgap_connect(bandgap_connect), .ground_connect(ground_connect),
    .ref_supply_sel(ref_supply_sel), .converter_power_on(converter_power_on),
    .sample_en(sample_en), .dac_code(dac_code), .cmp_above(cmp_above), .conv_irq(conv_irq));

  adcsq_analog_model #(.BANDGAP_LVL(BG)) analog (.pclk(pclk), .chan_level(chan_level),
    .chan_connect(chan_connect), .bandgap_connect(bandgap_connect),
    .ground_connect(ground_connect), .ref_supply_sel(ref_supply_sel),
    .converter_power_on(converter_power_on), .sample_en(sample_en), .dac_code(dac_code),
    .cmp_above(cmp_above));

  initial begin
    forever #20 pclk = ~pclk;
  end

  // =====================================================================
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [11:0] code_of(input int lvl, input logic [1:0] rf);
    int c;
    c = lvl * 4096 / ((rf == `ADCSQ_REF_VDD) ? 4096 : 2048);
    return (c > 4095) ? 12'hFFF : c[11:0];
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read notes are settled here, at the edge that completes the access
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      check(notes[0].what, prdata, notes[0].data);
      check("pslverr", {31'h0, pslverr}, {31'h0, notes[0].err});
      void'(notes.pop_front());
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] d, input logic e);
    notes.push_back('{what, d, e});
    apb(1'b0, a, 32'h0);
  endtask

  // counts edges until the watched output reaches the level
  task automatic wait_for(input logic irq_sel, input logic lvl, output int k);
    k = 0;
    while ((irq_sel ? conv_irq : sample_en) !== lvl && k < 5000) begin
      @(posedge pclk);
      #1;
      k++;
    end
    if (k >= 5000) begin
      failures++;
      summarize();
    end
  endtask

  task automatic start(input logic [7:0] c0);
    wr(`ADCSQ_OFF_CTRL_FIRST, {24'h0, 1'b1, c0[6:0]});
    wr(`ADCSQ_OFF_CTRL_FIRST, {24'h0, c0});
  endtask

  task automatic convert(input logic [2:0] src, input logic [3:0] ch, input logic [1:0] rf,
                         input logic [2:0] dv, input logic fmt, input int lvl);
    int p;
    int ns;
    logic [11:0] r;
    logic [7:0] c0;
    p = 1 << dv;
    r = code_of(lvl, rf);
    c0 = {3'b001, fmt, ch};
    wr(`ADCSQ_OFF_CTRL_SECOND, {29'h0, dv});
    wr(`ADCSQ_OFF_CTRL_FIRST, {24'h0, 3'b001, fmt, `ADCSQ_CH_FIRST_NONE});
    wr(`ADCSQ_OFF_CTRL_SECOND, {24'h0, src, rf, dv});
    wr(`ADCSQ_OFF_CTRL_FIRST, {24'h0, c0});
    wr(`ADCSQ_OFF_INT_CTRL, 32'h7);
    start(c0);
    wait_for(1'b0, 1'b1, ns);
    wait_for(1'b0, 1'b0, ns);
    check("sample_len", 32'(ns > 3 * p && ns <= 4 * p), 32'h1);
    wait_for(1'b1, 1'b1, ns);
    check("conv_len", 32'(ns), 32'(12 * p));
    rd("ctrl_first", `ADCSQ_OFF_CTRL_FIRST, {24'h0, c0}, 1'b0);
    if (dv >= 3'h2) begin
      rd("res_high", `ADCSQ_OFF_RESULT_HIGH,
         fmt ? {28'h0, r[11:8]} : {24'h0, r[11:4]}, 1'b0);
      rd("res_low", `ADCSQ_OFF_RESULT_LOW,
         fmt ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0}, 1'b0);
    end
    rd("int_ctrl", `ADCSQ_OFF_INT_CTRL, 32'h7, 1'b0);
    wr(`ADCSQ_OFF_INT_CTRL, 32'h7);
    rd("flag_clear", `ADCSQ_OFF_INT_CTRL, 32'h6, 1'b0);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      t = xs();
      chan_level[i*12 +: 12] <= (i == 7) ? 12'hFFF : t[11:0];
    end
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd("reset_value", 8'(a * 4), 32'h0, 1'b0);
    end
    rd("unmapped", 8'h18, 32'h0, 1'b1);
    $display("reset and map test done");

    for (int k = 0; k < 4; k++) begin
      t = xs();
      wr(`ADCSQ_OFF_PIN_ENABLE, {24'h0, t[7:0]});
      port_dir_input <= t[15:8];
      port_pullup_req <= t[23:16];
      @(posedge pclk);
      #1;
      check("analog_en", {24'h0, pin_analog_en}, {24'h0, t[7:0]});
      check("pullup", {24'h0, pin_pullup_en}, {24'h0, t[23:16] & ~t[7:0]});
      check("oe_n", {24'h0, pin_oe_n}, {24'h0, t[15:8] | t[7:0]});
    end
    wr(`ADCSQ_OFF_PIN_ENABLE, 32'hFF);
    rd("pin_enable", `ADCSQ_OFF_PIN_ENABLE, 32'hFF, 1'b0);
    $display("pin test done");

    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 16; c++) begin
        wr(`ADCSQ_OFF_CTRL_SECOND, {24'h0, 3'(s), 2'(c), 3'h0});
        wr(`ADCSQ_OFF_CTRL_FIRST, {28'h0, 4'(c)});
        #1;
        check("chan", {24'h0, chan_connect}, (c < 8) ? 32'(1 << c) : 32'h0);
        check("bandgap", {31'h0, bandgap_connect}, 32'(s == 1 && c >= 8));
        check("ground", {31'h0, ground_connect}, 32'(s >= 2 && s <= 4 && c >= 8));
        check("ref_sel", {31'h0, ref_supply_sel}, 32'(c % 4 == 1));
      end
    end
    $display("select test done");

    for (int d = 0; d < 8; d++) begin
      convert(`ADCSQ_SRC_EXT, 4'(d), `ADCSQ_REF_VDD, 3'(d), d[0], int'(chan_level[d*12 +: 12]));
    end
    for (int f = 0; f < 4; f++) begin
      convert(3'h5, 4'h5, 2'(f), 3'h2, f[0], int'(chan_level[60 +: 12]));
    end
    convert(3'h6, 4'h7, 2'h0, 3'h2, 1'b0, 4095);
    convert(`ADCSQ_SRC_BANDGAP, 4'h8, `ADCSQ_REF_VDD, 3'h3, 1'b0, BG);
    convert(`ADCSQ_SRC_GND_HI, 4'hC, 2'h0, 3'h2, 1'b1, 0);
    wr(`ADCSQ_OFF_RESULT_HIGH, 32'hFF);
    rd("res_readonly", `ADCSQ_OFF_RESULT_HIGH, 32'h0, 1'b0);
    $display("conversion test done");

    start(8'h23);
    wait_for(1'b0, 1'b1, n);
    rd("busy", `ADCSQ_OFF_CTRL_FIRST, 32'h63, 1'b0);
    wr(`ADCSQ_OFF_CTRL_FIRST, 32'hA3);
    @(posedge pclk);
    rd("abort", `ADCSQ_OFF_CTRL_FIRST, 32'hA3, 1'b0);
    wr(`ADCSQ_OFF_CTRL_FIRST, 32'h23);
    wait_for(1'b0, 1'b1, n);
    check("relaunch", 32'(n), 32'h2);
    wr(`ADCSQ_OFF_CTRL_FIRST, 32'h03);
    #1;
    check("power", {31'h0, converter_power_on}, 32'h0);
    @(posedge pclk);
    rd("power_off", `ADCSQ_OFF_CTRL_FIRST, 32'h03, 1'b0);
    rd("no_flag", `ADCSQ_OFF_INT_CTRL, 32'h6, 1'b0);
    #1;
    check("sample_off", {31'h0, sample_en}, 32'h0);
    $display("abort test done");
    summarize();
  end
endmodule
